// *** rtl/flr_serial_regs.sv ***
// serial-port slave and register bank of the flash led driver
// assumes scl, sda and enable arrive asynchronously from pins
// assumes an external pull-up resolves the open-drain data line
//
// Function
// - bit 0 lsb, bit 7 msb
// - read-only identification register at offset 00
// - pin roles and timer share offset 02
// - bits 7:6 select second pin role
// - bits 5:4 select first pin role
// - bits 3:0 flash timeout, default 1111
// - bits 7:3 flash current code
// - bits 2:0 torch current, default 011
// - chip address 30, bytes 60 and 61
// - enable rising edge restores all defaults
`timescale 1ns/1ps
`include "flr_defines.svh"

module flr_serial_regs
  import flr_pkg::*;
(
  input wire logic clk, // 50 MHz system clock
  input wire logic clk_en, // freezes all state while low
  input wire logic reset, // asynchronous, active high
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value, always low
  output logic sda_oe, // high while pulling the data line low
  input wire logic enable_pin, // device enable pin level
  output flr_cfg_type cfg // configuration fields for the driver
);

  localparam logic [2:0] SYNC_INIT = 3'h3;

  logic [2:0] pin_raw;
  logic [2:0] filt_w;
  logic [2:0] prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic enable_rise;

  flr_state_type state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic oe_q;
  flr_wr_type wr_q;
  logic [7:0] rd_data;

  function automatic logic rx_state(input flr_state_type s);
    return s == ST_ADDR || s == ST_SUB || s == ST_WRITE;
  endfunction

  assign pin_raw = {enable_pin, sda_in, scl_in};

  // three-stage synchronisers with agreement filter
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [2:0] stage_q;
      logic filt_q;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          stage_q <= {3{SYNC_INIT[g]}};
          filt_q <= SYNC_INIT[g];
        end else if (clk_en) begin
          stage_q <= {stage_q[1:0], pin_raw[g]};
          if (stage_q[1] == stage_q[2]) begin
            filt_q <= stage_q[2];
          end
        end
      end
      assign filt_w[g] = filt_q;
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_q <= SYNC_INIT;
    end else if (clk_en) begin
      prev_q <= filt_w;
    end
  end

  assign scl_rise = filt_w[0] && !prev_q[0];
  assign scl_fall = !filt_w[0] && prev_q[0];
  assign start_seen = filt_w[0] && prev_q[0] && prev_q[1] && !filt_w[1];
  assign stop_seen = filt_w[0] && prev_q[0] && !prev_q[1] && filt_w[1];
  assign enable_rise = filt_w[2] && !prev_q[2];

  // protocol sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (clk_en) begin
      if (stop_seen) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else if (start_seen) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (rx_state(state_q)) begin
          shift_q <= {shift_q[6:0], filt_w[1]};
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_READ) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_ACK_READ && filt_w[1]) begin
          state_q <= ST_IDLE;
        end
      end else if (scl_fall) begin
        unique case (state_q)
          ST_IDLE: begin
            oe_q <= 1'b0;
          end
          ST_ADDR: begin
            if (cnt_q == `FLR_BYTE_BITS) begin
              if (shift_q[7:1] == `FLR_CHIP_ADDR) begin
                state_q <= ST_ACK_ADDR;
                rw_q <= shift_q[0];
                oe_q <= 1'b1;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_SUB, ST_WRITE: begin
            if (cnt_q == `FLR_BYTE_BITS) begin
              state_q <= (state_q == ST_SUB) ? ST_ACK_SUB : ST_ACK_WRITE;
              oe_q <= 1'b1;
            end
          end
          ST_ACK_ADDR: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              state_q <= ST_READ;
              shift_q <= rd_data;
              oe_q <= !rd_data[7];
            end else begin
              state_q <= ST_SUB;
              oe_q <= 1'b0;
            end
          end
          ST_ACK_SUB, ST_ACK_WRITE: begin
            state_q <= ST_WRITE;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
          end
          ST_READ: begin
            if (cnt_q == `FLR_BYTE_BITS) begin
              state_q <= ST_ACK_READ;
              oe_q <= 1'b0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              oe_q <= !shift_q[6];
            end
          end
          ST_ACK_READ: begin
            state_q <= ST_READ;
            cnt_q <= 4'h0;
            shift_q <= rd_data;
            oe_q <= !rd_data[7];
          end
        endcase
      end
    end
  end

  // subaddress pointer, kept across a repeated start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_q <= 8'h00;
    end else if (clk_en) begin
      if (scl_fall && state_q == ST_SUB && cnt_q == `FLR_BYTE_BITS) begin
        ptr_q <= shift_q;
      end
    end
  end

  // one-cycle write strobe after the eighth data bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
    end else if (clk_en) begin
      wr_q.en <= scl_fall && state_q == ST_WRITE &&
                 cnt_q == `FLR_BYTE_BITS && !stop_seen && !start_seen;
      wr_q.addr <= ptr_q;
      wr_q.data <= shift_q;
    end
  end

  flr_reg_bank u_bank (
    .clk(clk),
    .clk_en(clk_en),
    .reset(reset),
    .load_defaults(enable_rise),
    .wr(wr_q),
    .rd_addr(ptr_q),
    .rd_data_q(rd_data),
    .cfg(cfg)
  );

  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  a_ack_own_addr: assert property (@(posedge clk) disable iff (reset)
    clk_en && scl_fall && !start_seen && !stop_seen &&
    state_q == ST_ADDR && cnt_q == `FLR_BYTE_BITS &&
    (shift_q == `FLR_WR_BYTE || shift_q == `FLR_RD_BYTE)
    |=> sda_oe && state_q == ST_ACK_ADDR)
    else $error("own address not acknowledged");

  a_skip_other: assert property (@(posedge clk) disable iff (reset)
    clk_en && scl_fall && !start_seen && !stop_seen &&
    state_q == ST_ADDR && cnt_q == `FLR_BYTE_BITS &&
    shift_q[7:1] != `FLR_CHIP_ADDR
    |=> !sda_oe && state_q == ST_IDLE)
    else $error("foreign address acknowledged");

  a_stop_release: assert property (@(posedge clk) disable iff (reset)
    clk_en && stop_seen |=> !sda_oe && state_q == ST_IDLE)
    else $error("data line held after stop");

  a_write_strobe: assert property (@(posedge clk) disable iff (reset)
    clk_en && wr_q.en |-> $past(state_q) == ST_WRITE && state_q == ST_ACK_WRITE)
    else $error("write strobe outside data byte");

endmodule

// *** rtl/flr_defines.svh ***
// constants of the flash led configuration registers
// assumes inclusion by bare name from the modules and the bench
`ifndef FLR_DEFINES_SVH
`define FLR_DEFINES_SVH

// register offsets (subaddress byte)
`define FLR_OFS_ID 8'h00
`define FLR_OFS_PIN 8'h02
`define FLR_OFS_CUR 8'h03

// serial port addressing
`define FLR_CHIP_ADDR 7'h30
`define FLR_WR_BYTE 8'h60
`define FLR_RD_BYTE 8'h61

// field positions, lowest bit of each field
`define FLR_PIN_TWO_LSB 6
`define FLR_PIN_ONE_LSB 4
`define FLR_TIMER_LSB 0
`define FLR_FLASH_LSB 3
`define FLR_TORCH_LSB 0

// reset values
`define FLR_PIN_RST 8'h0F
`define FLR_CUR_RST 8'h73
// identification value is arbitrary
`define FLR_ID_VALUE 8'hA5

// bits per byte on the serial port
`define FLR_BYTE_BITS 4'h8

`endif

// *** rtl/flr_pkg.sv ***
// types shared by the flash led configuration register files
// assumes flr_defines.svh is on the include path
package flr_pkg;

  typedef struct packed {
    logic [1:0] pin_two_role_select;
    logic [1:0] pin_one_role_select;
    logic [3:0] flash_timeout_code;
    logic [4:0] flash_current_code;
    logic [2:0] torch_current_code;
  } flr_cfg_type;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } flr_wr_type;

  typedef enum logic [1:0] {
    FLR_PIN_HIGHZ,
    FLR_PIN_MODE_A,
    FLR_PIN_MODE_B,
    FLR_PIN_MODE_C
  } flr_pin_role_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_SUB,
    ST_ACK_SUB,
    ST_WRITE,
    ST_ACK_WRITE,
    ST_READ,
    ST_ACK_READ
  } flr_state_type;

endpackage

// *** rtl/flr_reg_bank.sv ***
// register storage of the flash led configuration block
// assumes single-cycle write strobes from the serial port logic
`timescale 1ns/1ps
`include "flr_defines.svh"

module flr_reg_bank
  import flr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic clk_en, // freezes all state while low
  input wire logic reset, // asynchronous, active high
  input wire logic load_defaults, // one-cycle pulse, restore defaults
  input flr_wr_type wr, // write strobe, offset and data
  input wire logic [7:0] rd_addr, // read offset
  output logic [7:0] rd_data_q, // registered read data
  output flr_cfg_type cfg // field values for the driver
);

  logic [7:0] pin_q;
  logic [7:0] cur_q;

  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input logic [7:0] p,
                                          input logic [7:0] c);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `FLR_OFS_ID: r = `FLR_ID_VALUE;
      `FLR_OFS_PIN: r = p;
      `FLR_OFS_CUR: r = c;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // pin roles and timer share one register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_q <= `FLR_PIN_RST;
    end else if (clk_en) begin
      if (load_defaults) begin
        pin_q <= `FLR_PIN_RST;
      end else if (wr.en && wr.addr == `FLR_OFS_PIN) begin
        pin_q <= wr.data;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_q <= `FLR_CUR_RST;
    end else if (clk_en) begin
      if (load_defaults) begin
        cur_q <= `FLR_CUR_RST;
      end else if (wr.en && wr.addr == `FLR_OFS_CUR) begin
        cur_q <= wr.data;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_q <= 8'h00;
    end else if (clk_en) begin
      rd_data_q <= read_mux(rd_addr, pin_q, cur_q);
    end
  end

  // bit 7 of each register is its msb
  assign cfg = {pin_q, cur_q};

  a_id_fixed: assert property (@(posedge clk) disable iff (reset)
    clk_en && rd_addr == `FLR_OFS_ID |=> rd_data_q == `FLR_ID_VALUE)
    else $error("identification readback wrong");

  a_pin_write: assert property (@(posedge clk) disable iff (reset)
    clk_en && !load_defaults && wr.en && wr.addr == `FLR_OFS_PIN
    |=> pin_q == $past(wr.data))
    else $error("pin register write lost");

  a_cur_write: assert property (@(posedge clk) disable iff (reset)
    clk_en && !load_defaults && wr.en && wr.addr == `FLR_OFS_CUR
    |=> cur_q == $past(wr.data))
    else $error("current register write lost");

  a_enable_default: assert property (@(posedge clk) disable iff (reset)
    clk_en && load_defaults
    |=> pin_q == `FLR_PIN_RST && cur_q == `FLR_CUR_RST)
    else $error("defaults not restored");

  a_field_map: assert property (@(posedge clk) disable iff (reset)
    cfg.pin_two_role_select == pin_q[`FLR_PIN_TWO_LSB+:2] &&
    cfg.pin_one_role_select == pin_q[`FLR_PIN_ONE_LSB+:2] &&
    cfg.flash_timeout_code == pin_q[`FLR_TIMER_LSB+:4] &&
    cfg.flash_current_code == cur_q[`FLR_FLASH_LSB+:5] &&
    cfg.torch_current_code == cur_q[`FLR_TORCH_LSB+:3])
    else $error("field layout wrong");

endmodule

// *** dv/flr_host_model.sv ***
// host-side serial master model for the configuration port
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps

module flr_host_model (
  input wire logic clk, // system clock, paces the bit phases
  input wire logic sda_line, // resolved data line level
  output logic scl, // serial clock, high while idle
  output logic sda_m // data drive, 1 releases the line
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // also a repeated start, since scl is low between bytes
  task automatic start();
    sda_m = 1'b1;
    wt(5);
    scl = 1'b1;
    wt(10);
    sda_m = 1'b0;
    wt(10);
    scl = 1'b0;
    wt(5);
  endtask

  task automatic stop();
    sda_m = 1'b0;
    wt(5);
    scl = 1'b1;
    wt(10);
    sda_m = 1'b1;
    wt(10);
  endtask

  // phases of five clocks keep well clear of the pin filter
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    wt(5);
    scl = 1'b1;
    wt(5);
    r = sda_line;
    wt(5);
    scl = 1'b0;
    wt(5);
  endtask

  // msb first, ninth bit is the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(mack, ack);
  endtask
endmodule

// *** dv/tb_flr_serial_regs.sv ***
// self-checking bench of the serial configuration registers
// assumes flr_defines.svh on the include path and the host model
`timescale 1ns/1ps
`include "flr_defines.svh"

module tb_flr_serial_regs
  import flr_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic enable_pin = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  flr_cfg_type cfg;
  int error_cnt = 0;
  int n_compared = 0;

  always #10 clk = ~clk;
  assign sda_line = sda_m & ~(sda_oe & ~sda_out);

  flr_serial_regs u_flr_serial_regs (.clk(clk), .clk_en(clk_en),
    .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .enable_pin(enable_pin), .cfg(cfg));
  flr_host_model u_flr_host_model (.clk(clk), .sda_line(sda_line),
    .scl(scl), .sda_m(sda_m));

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr_reg(input logic [7:0] sub, d);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    u_flr_host_model.start();
    u_flr_host_model.xfer(`FLR_WR_BYTE, 1'b1, rx, a0);
    u_flr_host_model.xfer(sub, 1'b1, rx, a1);
    u_flr_host_model.xfer(d, 1'b1, rx, a2);
    u_flr_host_model.stop();
    chk({15'h0, a0 | a1 | a2}, 16'h0, "write not acked");
  endtask

  task automatic rd_reg(input logic [7:0] sub, output logic [7:0] d);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    u_flr_host_model.start();
    u_flr_host_model.xfer(`FLR_WR_BYTE, 1'b1, rx, a0);
    u_flr_host_model.xfer(sub, 1'b1, rx, a1);
    u_flr_host_model.start();
    u_flr_host_model.xfer(`FLR_RD_BYTE, 1'b1, rx, a2);
    u_flr_host_model.xfer(8'hFF, 1'b1, d, a3);
    u_flr_host_model.stop();
    chk({15'h0, a0 | a1 | a2}, 16'h0, "read not acked");
  endtask

  task automatic t_defaults();
    logic [7:0] d;
    chk(cfg, {`FLR_PIN_RST, `FLR_CUR_RST}, "cfg default");
    chk(cfg.flash_timeout_code, 16'hF, "timeout default");
    chk(cfg.torch_current_code, 16'h3, "torch default");
    rd_reg(`FLR_OFS_ID, d);
    chk(d, `FLR_ID_VALUE, "id value");
    rd_reg(`FLR_OFS_PIN, d);
    chk(d, 16'h0F, "pin reg default");
    $display("test defaults done");
  endtask

  task automatic t_id_ro();
    logic [7:0] d;
    wr_reg(`FLR_OFS_ID, 8'h5A);
    rd_reg(`FLR_OFS_ID, d);
    chk(d, `FLR_ID_VALUE, "id written");
    $display("test id read-only done");
  endtask

  task automatic t_pin();
    logic [7:0] d;
    logic [7:0] v;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      // first pin never gets the reserved code
      v = {c, (c == 2'h3) ? 2'h2 : c, c, c};
      wr_reg(`FLR_OFS_PIN, v);
      chk(cfg.pin_two_role_select, v[7:6], "pin two role");
      chk(cfg.pin_one_role_select, v[5:4], "pin one role");
      chk(cfg.flash_timeout_code, v[3:0], "timeout code");
      rd_reg(`FLR_OFS_PIN, d);
      chk(d, v, "pin reg readback");
    end
    $display("test pin fields done");
  endtask

  task automatic t_cur();
    logic [7:0] d;
    logic [7:0] vals [3] = '{8'h08, 8'hF7, 8'h86};
    foreach (vals[i]) begin
      wr_reg(`FLR_OFS_CUR, vals[i]);
      chk(cfg.flash_current_code, vals[i][7:3], "flash code");
      chk(cfg.torch_current_code, vals[i][2:0], "torch code");
      rd_reg(`FLR_OFS_CUR, d);
      chk(d, vals[i], "current readback");
    end
    $display("test current fields done");
  endtask

  task automatic t_addr();
    logic [7:0] rx;
    logic a;
    u_flr_host_model.start();
    u_flr_host_model.xfer(8'h62, 1'b1, rx, a);
    u_flr_host_model.stop();
    chk({15'h0, a}, 16'h1, "foreign address acked");
    $display("test address match done");
  endtask

  task automatic t_enable();
    logic [7:0] d;
    // fields still hold the last pin and current writes here
    @(negedge clk);
    clk_en = 1'b0;
    enable_pin = 1'b1;
    repeat (10) @(negedge clk);
    chk(cfg, 16'hEF86, "state frozen by clock enable");
    clk_en = 1'b1;
    repeat (10) @(negedge clk);
    chk(cfg, {`FLR_PIN_RST, `FLR_CUR_RST}, "enable defaults");
    rd_reg(`FLR_OFS_CUR, d);
    chk(d, `FLR_CUR_RST, "enable current reg");
    $display("test enable reload done");
  endtask

  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (5) @(negedge clk);
    t_defaults();
    t_id_ro();
    t_pin();
    t_cur();
    t_addr();
    t_enable();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
